//--- include/oled_pkg.sv
package oled_pkg;

	// ==========================================================
	// Serial target addressing and control byte layout
	// ==========================================================
	localparam logic [5:0] ADDR_UPPER = 6'h1e;
	localparam int CO_BIT = 7;
	localparam int DC_BIT = 6;
	localparam int RW_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ==========================================================
	// Command opcodes
	// ==========================================================
	localparam logic [7:0] CMD_CONTRAST = 8'h81;
	localparam logic [7:0] CMD_CLOCK = 8'hd5;
	localparam logic [7:0] CMD_MUX = 8'ha8;
	localparam logic [7:0] CMD_PHASE = 8'hd9;
	localparam logic [7:0] CMD_START_LINE = 8'ha2;
	localparam logic [7:0] CMD_COLUMN = 8'h15;
	localparam logic [7:0] CMD_DISP_OFF = 8'hae;
	localparam logic [7:0] CMD_DISP_ON = 8'haf;
	localparam logic [7:0] CMD_SEG_NORMAL = 8'ha0;
	localparam logic [7:0] CMD_SEG_REMAP = 8'ha1;
	localparam logic [7:0] CMD_COM_NORMAL = 8'hc0;
	localparam logic [7:0] CMD_COM_REVERSE = 8'hc8;
	localparam logic [5:0] CMD_MODE_BASE = 6'h29;

	// ==========================================================
	// Reset values and timing constants
	// ==========================================================
	localparam logic [7:0] CONTRAST_RST = 8'h7f;
	localparam logic [7:0] MUX_RST = 8'h9f;
	localparam logic [3:0] PHASE1_RST = 4'h7;
	localparam logic [3:0] PHASE2_RST = 4'h2;
	localparam logic [3:0] DIV_RST = 4'h0;
	localparam logic [3:0] OSC_FREQ_RST = 4'h8;
	localparam logic [7:0] ROW_CLK_K0 = 8'h42;
	localparam logic [6:0] COL_LAST = 7'h4f;
	localparam logic [5:0] OSC_BASE_CYC = 6'h20;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CTRL = 3'b011,
		ST_BYTE = 3'b010,
		ST_STREAM = 3'b110,
		ST_IGNORE = 3'b111
	} i2c_state_t;

	typedef struct packed {
		logic display_on;
		logic [1:0] disp_mode;
		logic seg_remap;
		logic com_reverse;
		logic [7:0] contrast;
		logic [3:0] osc_freq;
		logic [3:0] div;
		logic [7:0] mux;
		logic [3:0] phase1;
		logic [3:0] phase2;
		logic [7:0] start_line;
	} cfg_t;

	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} ram_wr_t;

endpackage : oled_pkg

//--- hdl/display_timing.sv
module display_timing (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic op_tick_i,
	input wire oled_pkg::cfg_t cfg_i,
	output logic display_clock_o,
	output logic frame_sync_pulse_o,
	output logic [7:0] row_o
);

	typedef struct packed {
		logic [3:0] div_cnt;
		logic [7:0] k_cnt;
		logic [7:0] row;
		logic display_clock;
		logic frame;
	} tstate_t;

	tstate_t s_reg;
	tstate_t s_next;
	logic [7:0] k_last;

	// Clocks per row, less one; widest case 95 fits in 8 bits
	// row length K
	assign k_last = {4'h0, cfg_i.phase1} + {4'h0, cfg_i.phase2}
		+ oled_pkg::ROW_CLK_K0 - 8'h01;

	// ==========================================================
	// Divider, row counter and frame marker
	// ==========================================================
	always_comb begin
		s_next = s_reg;
		s_next.display_clock = 1'b0;
		if (op_tick_i) begin
			if (s_reg.div_cnt >= cfg_i.div) begin
				s_next.div_cnt = 4'h0;
				s_next.display_clock = 1'b1;
			end else begin
				s_next.div_cnt = s_reg.div_cnt + 4'h1;
			end
		end
		if (s_reg.display_clock) begin
			if (s_reg.k_cnt >= k_last) begin
				s_next.k_cnt = 8'h00;
				if (s_reg.row >= cfg_i.mux) begin
					s_next.row = 8'h00;
				end else begin
					s_next.row = s_reg.row + 8'h01;
				end
				s_next.frame = (s_reg.row >= cfg_i.mux);
			end else begin
				s_next.k_cnt = s_reg.k_cnt + 8'h01;
			end
		end
	end

	// Registered copy of the whole timing state
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign display_clock_o = s_reg.display_clock;
	assign frame_sync_pulse_o = s_reg.frame;
	assign row_o = s_reg.row;

endmodule : display_timing

//--- hdl/oled_i2c_write_front_end.sv
// Functional notes
// - SDA falling while SCL high is a start condition.
// - Answer address 0111100 with select low, 0111101 with select high.
// - Read/write bit zero selects write; only writes are accepted.
// - Hold SDA low through the ninth clock high after the address.
// - After address: control byte with continuation and select bits.
// - Continuation zero makes all further bytes data bytes.
// - Select zero routes to command decoder, one to display RAM.
// - Column pointer advances by one after each RAM write.
// - Acknowledge every control byte and every data byte.
// - SDA rising while SCL high ends the transfer; go idle.
// - Parallel byte: select high is RAM data, low is a command.
// - Source select high uses internal oscillator, low external clock.
// - Clock command upper nibble sets oscillator rate, higher is faster.
// - Clock command lower nibble sets display clock divide ratio.
// - Row lasts phase1 plus phase2 plus 66 display clocks.
// - New frame after ratio times K times mux operating clocks.
// - Multiplex ratio from its command, reset 159 for 160 rows.
// - Reset clears shift register, start line and column counter.
// - Reset: display off, full mux, no remap, normal scan, contrast 7f.
module oled_i2c_write_front_end #(
	parameter logic [5:0] OSC_BASE = oled_pkg::OSC_BASE_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_select_bit_i,
	input wire logic par_wr_i,
	input wire logic par_dc_i,
	input wire logic [7:0] par_data_i,
	input wire logic clock_source_select_i,
	input wire logic ext_clock_input_i,
	output logic osc_enable_o,
	output oled_pkg::ram_wr_t ram_wr_o,
	output logic [6:0] column_o,
	output oled_pkg::cfg_t cfg_o,
	output logic display_clock_o,
	output logic frame_sync_pulse_o,
	output logic [7:0] row_o
);

	typedef struct packed {
		oled_pkg::i2c_state_t st;
		logic scl_q;
		logic sda_q;
		logic ext_q;
		logic [7:0] shift;
		logic [3:0] bits;
		logic dc;
		logic ack;
		logic sda_oe;
		logic sda_out;
		logic pend;
		logic [7:0] pend_cmd;
		oled_pkg::cfg_t cfg;
		oled_pkg::ram_wr_t ram;
		logic [6:0] col;
		logic [5:0] osc_cnt;
		logic op_tick;
		logic osc_en;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// True when the byte targets this device in write direction
	function automatic logic addr_hit(input logic [7:0] b, input logic sel);
		addr_hit = (b[7:1] == {oled_pkg::ADDR_UPPER, sel})
			&& !b[oled_pkg::RW_BIT];
	endfunction : addr_hit

	// Wrap the column pointer at the end of a row of bytes
	function automatic logic [6:0] col_inc(input logic [6:0] c);
		col_inc = (c >= oled_pkg::COL_LAST) ? 7'h00 : c + 7'h01;
	endfunction : col_inc

	// ==========================================================
	// Serial target, byte steering and command decoder
	// ==========================================================
	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic byte_v;
		logic byte_dc;
		logic [7:0] byte_d;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		byte_v = 1'b0;
		byte_dc = 1'b0;
		byte_d = 8'h00;
		s_next = s_reg;
		s_next.scl_q = scl_i;
		s_next.sda_q = sda_i;
		s_next.ext_q = ext_clock_input_i;
		s_next.ram.we = 1'b0;
		scl_rise = scl_i && !s_reg.scl_q;
		scl_fall = !scl_i && s_reg.scl_q;
		// edges on SDA with SCL high are framing only
		start_c = scl_i && s_reg.scl_q && s_reg.sda_q && !sda_i;
		stop_c = scl_i && s_reg.scl_q && !s_reg.sda_q && sda_i;

		if (start_c) begin
			// Repeated start is handled the same as a first start
			s_next.st = oled_pkg::ST_ADDR;
			s_next.bits = 4'h0;
			s_next.ack = 1'b0;
			s_next.sda_oe = 1'b0;
		end else if (stop_c) begin
			s_next.st = oled_pkg::ST_IDLE;
			s_next.bits = 4'h0;
			s_next.ack = 1'b0;
			s_next.sda_oe = 1'b0;
		end else if (s_reg.st != oled_pkg::ST_IDLE
				&& s_reg.st != oled_pkg::ST_IGNORE) begin
			if (s_reg.ack) begin
				// Release SDA at the fall closing the ninth clock
				if (scl_fall) begin
					s_next.ack = 1'b0;
					s_next.sda_oe = 1'b0;
				end
			end else if (scl_rise && s_reg.bits < oled_pkg::BITS_PER_BYTE) begin
				s_next.shift = {s_reg.shift[6:0], sda_i};
				s_next.bits = s_reg.bits + 4'h1;
			end else if (scl_fall && s_reg.bits == oled_pkg::BITS_PER_BYTE) begin
				s_next.bits = 4'h0;
				// drive low for the ninth clock
				s_next.ack = 1'b1;
				s_next.sda_oe = 1'b1;
				unique case (s_reg.st)
					oled_pkg::ST_ADDR: begin
						if (addr_hit(s_reg.shift, addr_select_bit_i)) begin
							s_next.st = oled_pkg::ST_CTRL;
						end else begin
							// Not ours or a read: stay off the bus
							s_next.st = oled_pkg::ST_IGNORE;
							s_next.ack = 1'b0;
							s_next.sda_oe = 1'b0;
						end
					end
					oled_pkg::ST_CTRL: begin
						s_next.dc = s_reg.shift[oled_pkg::DC_BIT];
						s_next.st = s_reg.shift[oled_pkg::CO_BIT]
							? oled_pkg::ST_BYTE : oled_pkg::ST_STREAM;
					end
					oled_pkg::ST_BYTE: begin
						byte_v = 1'b1;
						byte_dc = s_reg.dc;
						byte_d = s_reg.shift;
						s_next.st = oled_pkg::ST_CTRL;
					end
					oled_pkg::ST_STREAM: begin
						byte_v = 1'b1;
						byte_dc = s_reg.dc;
						byte_d = s_reg.shift;
					end
					default: begin
						s_next.st = oled_pkg::ST_IDLE;
					end
				endcase
			end
		end

		// Parallel strobe takes the decoder when both arrive together
		// pin-selected byte steering
		if (par_wr_i) begin
			byte_v = 1'b1;
			byte_dc = par_dc_i;
			byte_d = par_data_i;
		end

		// route to RAM or command decoder
		if (byte_v && byte_dc) begin
			s_next.ram.we = 1'b1;
			s_next.ram.addr = s_reg.col;
			s_next.ram.data = byte_d;
			s_next.col = col_inc(s_reg.col);
		end else if (byte_v && s_reg.pend) begin
			s_next.pend = 1'b0;
			unique case (s_reg.pend_cmd)
				oled_pkg::CMD_CONTRAST: s_next.cfg.contrast = byte_d;
				oled_pkg::CMD_CLOCK: begin
					s_next.cfg.osc_freq = byte_d[7:4];
					s_next.cfg.div = byte_d[3:0];
				end
				oled_pkg::CMD_MUX: s_next.cfg.mux = byte_d;
				oled_pkg::CMD_PHASE: begin
					s_next.cfg.phase1 = byte_d[3:0];
					s_next.cfg.phase2 = byte_d[7:4];
				end
				oled_pkg::CMD_START_LINE: s_next.cfg.start_line = byte_d;
				oled_pkg::CMD_COLUMN: s_next.col = byte_d[6:0];
				default: s_next.pend = 1'b0;
			endcase
		end else if (byte_v) begin
			unique case (byte_d)
				oled_pkg::CMD_CONTRAST, oled_pkg::CMD_CLOCK,
				oled_pkg::CMD_MUX, oled_pkg::CMD_PHASE,
				oled_pkg::CMD_START_LINE, oled_pkg::CMD_COLUMN: begin
					// Two-byte command: next command byte is its argument
					s_next.pend = 1'b1;
					s_next.pend_cmd = byte_d;
				end
				oled_pkg::CMD_DISP_OFF: s_next.cfg.display_on = 1'b0;
				oled_pkg::CMD_DISP_ON: s_next.cfg.display_on = 1'b1;
				oled_pkg::CMD_SEG_NORMAL: s_next.cfg.seg_remap = 1'b0;
				oled_pkg::CMD_SEG_REMAP: s_next.cfg.seg_remap = 1'b1;
				oled_pkg::CMD_COM_NORMAL: s_next.cfg.com_reverse = 1'b0;
				oled_pkg::CMD_COM_REVERSE: s_next.cfg.com_reverse = 1'b1;
				default: begin
					// Display mode group occupies four codes
					if (byte_d[7:2] == oled_pkg::CMD_MODE_BASE) begin
						s_next.cfg.disp_mode = byte_d[1:0];
					end
				end
			endcase
		end

		// ======================================================
		// Operating clock source
		// ======================================================
		// source select
		s_next.osc_en = clock_source_select_i;
		s_next.op_tick = 1'b0;
		if (clock_source_select_i) begin
			if (s_reg.osc_cnt == 6'h00) begin
				s_next.osc_cnt = OSC_BASE - {2'b00, s_reg.cfg.osc_freq};
				s_next.op_tick = 1'b1;
			end else begin
				s_next.osc_cnt = s_reg.osc_cnt - 6'h01;
			end
		end else begin
			s_next.osc_cnt = 6'h00;
			s_next.op_tick = ext_clock_input_i && !s_reg.ext_q;
		end
	end

	// ==========================================================
	// State register
	// ==========================================================
	// The bus lines idle high, so their history resets high too
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_reg <= '0;
			s_reg.st <= oled_pkg::ST_IDLE;
			s_reg.scl_q <= 1'b1;
			s_reg.sda_q <= 1'b1;
			// shift register, start line, column cleared
			s_reg.shift <= 8'h00;
			s_reg.col <= 7'h00;
			s_reg.cfg.start_line <= 8'h00;
			s_reg.cfg.display_on <= 1'b0;
			s_reg.cfg.seg_remap <= 1'b0;
			s_reg.cfg.com_reverse <= 1'b0;
			s_reg.cfg.disp_mode <= 2'b00;
			s_reg.cfg.contrast <= oled_pkg::CONTRAST_RST;
			s_reg.cfg.mux <= oled_pkg::MUX_RST;
			s_reg.cfg.phase1 <= oled_pkg::PHASE1_RST;
			s_reg.cfg.phase2 <= oled_pkg::PHASE2_RST;
			s_reg.cfg.div <= oled_pkg::DIV_RST;
			s_reg.cfg.osc_freq <= oled_pkg::OSC_FREQ_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Display time generator
	// ==========================================================
	// frame timing from operating clock
	display_timing u_timing (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.op_tick_i(s_reg.op_tick),
		.cfg_i(s_reg.cfg),
		.display_clock_o(display_clock_o),
		.frame_sync_pulse_o(frame_sync_pulse_o),
		.row_o(row_o)
	);

	// Outputs straight from the state register
	assign sda_o = s_reg.sda_out;
	assign sda_oe_o = s_reg.sda_oe;
	assign osc_enable_o = s_reg.osc_en;
	assign ram_wr_o = s_reg.ram;
	assign column_o = s_reg.col;
	assign cfg_o = s_reg.cfg;

endmodule : oled_i2c_write_front_end

//--- dv/oled_front_end_sva.sv
// ==========================================================
// Port-level checks of the serial front end
// ==========================================================
module oled_front_end_sva #(
	parameter logic [5:0] OSC_BASE = 6'h20
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic addr_select_bit_i,
	input wire logic par_wr_i,
	input wire logic par_dc_i,
	input wire logic [7:0] par_data_i,
	input wire logic clock_source_select_i,
	input wire logic ext_clock_input_i,
	input wire logic osc_enable_o,
	input wire oled_pkg::ram_wr_t ram_wr_o,
	input wire logic [6:0] column_o,
	input wire oled_pkg::cfg_t cfg_o,
	input wire logic display_clock_o,
	input wire logic frame_sync_pulse_o,
	input wire logic [7:0] row_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	chk_ack_starts_low: assert property (
		$rose(sda_oe_o) |-> !scl_i)
		else $error("ack raised while clock high");
	chk_ack_span: assert property (
		(sda_oe_o && scl_i) |=> (sda_oe_o || !scl_i))
		else $error("ack dropped during clock high");
	chk_ack_release: assert property (
		$fell(sda_oe_o) |-> !scl_i && !$past(scl_i))
		else $error("ack released outside clock low");
	chk_stop_idle: assert property (
		scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*4])
		else $error("data line driven after stop");
	// column steps by one, wrapping at the row end
	chk_col_step: assert property (
		ram_wr_o.we |=> column_o ==
		(($past(ram_wr_o.addr) == oled_pkg::COL_LAST) ? 7'h00
		: $past(ram_wr_o.addr) + 7'h01))
		else $error("column pointer did not advance");
	chk_par_data: assert property (
		par_wr_i && par_dc_i |=> ram_wr_o.we &&
		ram_wr_o.data == $past(par_data_i))
		else $error("parallel data byte not written");
	chk_par_cmd: assert property (
		par_wr_i && !par_dc_i |=> !ram_wr_o.we)
		else $error("command byte reached the RAM");
	chk_osc_select: assert property (
		$past(nrst_i) |-> osc_enable_o == $past(clock_source_select_i))
		else $error("oscillator enable wrong");
	chk_fs_row_zero: assert property (
		$rose(frame_sync_pulse_o) |-> row_o == 8'h00)
		else $error("frame sync not at row zero");
	chk_reset_cfg: assert property (
		$rose(nrst_i) |-> cfg_o.contrast == oled_pkg::CONTRAST_RST &&
		cfg_o.mux == oled_pkg::MUX_RST && !cfg_o.display_on &&
		column_o == 7'h00)
		else $error("reset configuration wrong");
endmodule : oled_front_end_sva

bind oled_i2c_write_front_end oled_front_end_sva #(.OSC_BASE(OSC_BASE)) chk_u (
	.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_bit_i(addr_select_bit_i),
	.par_wr_i(par_wr_i), .par_dc_i(par_dc_i), .par_data_i(par_data_i),
	.clock_source_select_i(clock_source_select_i),
	.ext_clock_input_i(ext_clock_input_i), .osc_enable_o(osc_enable_o),
	.ram_wr_o(ram_wr_o), .column_o(column_o), .cfg_o(cfg_o),
	.display_clock_o(display_clock_o),
	.frame_sync_pulse_o(frame_sync_pulse_o), .row_o(row_o));

//--- dv/i2c_host_model.sv
// ==========================================================
// Bus master model; lines idle high through the pull-ups
// ==========================================================
module i2c_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Each phase spans several clocks so the target sees it twice
	task wait4;
		repeat (4) @(posedge clk_i);
	endtask : wait4

	task start_c;
		@(posedge clk_i);
		sda_o <= 1'b0;
		wait4();
		scl_o <= 1'b0;
		wait4();
	endtask : start_c

	// data moves only while clock low
	task bit_w(input logic v, output logic s);
		repeat (2) @(posedge clk_i);
		sda_o <= v;
		wait4();
		scl_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		s = sda_i;
		repeat (2) @(posedge clk_i);
		scl_o <= 1'b0;
	endtask : bit_w

	// Sends MSB first, then releases the line to read the ack
	task byte_w(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_w(d[i], s);
		end
		bit_w(1'b1, s);
		ack = !s;
	endtask : byte_w

	task stop_c;
		repeat (2) @(posedge clk_i);
		sda_o <= 1'b0;
		wait4();
		scl_o <= 1'b1;
		wait4();
		sda_o <= 1'b1;
		wait4();
	endtask : stop_c
endmodule : i2c_host_model

//--- dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OSC_P = 32;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic scl, sda_m, sda_o, sda_oe, osc_en, display_clock, fs;
	logic sel = 1'b0;
	logic par_wr = 1'b0;
	logic par_dc = 1'b0;
	logic [7:0] par_data = 8'h00;
	logic css = 1'b1;
	logic ext_clk = 1'b0;
	logic ext_en = 1'b0;
	logic [6:0] column;
	logic [7:0] row;
	oled_pkg::ram_wr_t ram_wr;
	oled_pkg::cfg_t cfg;
	logic [14:0] wr_q[$];
	int err_total = 0;
	int compares = 0;
	int n;
	int fs_rises = 0;
	// Open-drain data line with pull-up
	wire logic sda_w = sda_oe ? 1'b0 : sda_m;

	// ==========================================================
	// Clocks, model and design
	// ==========================================================
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (ext_en) ext_clk <= ~ext_clk;
	// Log every RAM write as address and data
	always @(posedge clk_i) begin
		if (ram_wr.we === 1'b1) begin
			wr_q.push_back({ram_wr.addr, ram_wr.data});
		end
	end
	// Count frame sync rises for the host timing tests
	always @(posedge fs) fs_rises <= fs_rises + 1;

	i2c_host_model m_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

	oled_i2c_write_front_end #(.OSC_BASE(6'(OSC_P))) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_bit_i(sel),
		.par_wr_i(par_wr), .par_dc_i(par_dc), .par_data_i(par_data),
		.clock_source_select_i(css), .ext_clock_input_i(ext_clk),
		.osc_enable_o(osc_en), .ram_wr_o(ram_wr), .column_o(column),
		.cfg_o(cfg), .display_clock_o(display_clock), .frame_sync_pulse_o(fs),
		.row_o(row));

	// ==========================================================
	// Compare, access and closing tasks
	// ==========================================================
	task cmp_v(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_v

	task cmp_b(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_b

	task tally_and_finish;
		$display("compares=%0d mismatches=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Bytes are packed MSB first into b; every one must match ack_exp
	task i2c_seq(input logic [63:0] b, input int cnt, input logic ack_exp);
		logic ack;
		m_u.start_c();
		for (int i = 0; i < cnt; i++) begin
			m_u.byte_w(b[63-8*i -: 8], ack);
			cmp_b(ack, ack_exp);
		end
		m_u.stop_c();
	endtask : i2c_seq

	// Strobe held one cycle, then a quiet cycle so calls never collide
	task par_w(input logic dc, input logic [7:0] d);
		@(posedge clk_i);
		par_wr <= 1'b1;
		par_dc <= dc;
		par_data <= d;
		@(posedge clk_i);
		par_wr <= 1'b0;
		@(posedge clk_i);
	endtask : par_w

	task wr_chk(input logic [14:0] exp);
		logic [14:0] g;
		// Let the logger take a write landing on this very edge
		#1;
		g = (wr_q.size() > 0) ? wr_q.pop_front() : 15'h7fff;
		cmp_v({1'b0, g}, {1'b0, exp});
	endtask : wr_chk

	// Cycles between two rising edges of frame sync or display clock
	task gap(input logic use_fs, output int len);
		int t0;
		logic p, s;
		t0 = -1;
		len = 0;
		p = 1'b1;
		for (int i = 0; i < 5000 && len == 0; i++) begin
			@(posedge clk_i);
			#1;
			s = use_fs ? fs : display_clock;
			if (s && !p) begin
				if (t0 >= 0) len = i - t0;
				else t0 = i;
			end
			p = s;
		end
	endtask : gap

	// ==========================================================
	// Test sequence
	// ==========================================================
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		cmp_v({cfg.contrast, cfg.mux}, 16'h7f9f);
		cmp_v({cfg.phase1, cfg.phase2, cfg.start_line}, 16'h7200);
		cmp_v({4'h0, cfg.display_on, cfg.disp_mode, cfg.seg_remap,
			cfg.com_reverse, column}, 16'h0000);
		cmp_b(sda_o, 1'b0);
		$display("test reset_defaults done");
		i2c_seq(64'h7840abcd_00000000, 4, 1'b1);
		wr_chk({7'h00, 8'hab});
		wr_chk({7'h01, 8'hcd});
		cmp_v({9'h000, column}, 16'h0002);
		$display("test ram_stream done");
		i2c_seq(64'h79000000_00000000, 1, 1'b0);
		i2c_seq(64'h7a4011_0000000000, 3, 1'b0);
		cmp_v(16'(wr_q.size()), 16'h0000);
		$display("test refused_address done");
		sel <= 1'b1;
		i2c_seq(64'h7a808180_3380af00, 7, 1'b1);
		cmp_v({8'h00, cfg.contrast}, 16'h0033);
		cmp_b(cfg.display_on, 1'b1);
		i2c_seq(64'h7a00a803_00000000, 4, 1'b1);
		cmp_v({8'h00, cfg.mux}, 16'h0003);
		$display("test command_bytes done");
		par_w(1'b0, 8'hd5);
		par_w(1'b0, 8'h01);
		par_w(1'b1, 8'h5a);
		cmp_v({8'h00, cfg.osc_freq, cfg.div}, 16'h0001);
		wr_chk({7'h02, 8'h5a});
		$display("test parallel_port done");
		gap(1'b0, n);
		cmp_v(16'(n), 16'((OSC_P + 1) * 2));
		par_w(1'b0, 8'hd5);
		par_w(1'b0, 8'hf1);
		gap(1'b0, n);
		cmp_v(16'(n), 16'((OSC_P - 15 + 1) * 2));
		$display("test osc_rate done");
		css <= 1'b0;
		ext_en <= 1'b1;
		repeat (2) @(posedge clk_i);
		cmp_b(osc_en, 1'b0);
		gap(1'b1, n);
		cmp_v(16'(n), 16'(2 * 2 * (7 + 2 + 66) * 4));
		$display("test frame_period done");
		// Remap, scan, mode, start line, phase and column commands
		par_w(1'b0, 8'ha1);
		par_w(1'b0, 8'hc8);
		par_w(1'b0, 8'ha6);
		par_w(1'b0, 8'ha2);
		par_w(1'b0, 8'h10);
		par_w(1'b0, 8'hd9);
		par_w(1'b0, 8'h35);
		par_w(1'b0, 8'h15);
		par_w(1'b0, 8'h4e);
		cmp_v({cfg.phase1, cfg.phase2, cfg.start_line}, 16'h5310);
		cmp_v({4'h0, cfg.display_on, cfg.disp_mode, cfg.seg_remap,
			cfg.com_reverse, column}, 16'h0dce);
		gap(1'b1, n);
		cmp_v(16'(n), 16'(2 * 2 * (5 + 3 + 66) * 4));
		$display("test more_commands done");
		// Fast host: whole write between two sync rises
		@(posedge fs);
		@(posedge clk_i);
		n = fs_rises;
		i2c_seq(64'h7a401122_00000000, 4, 1'b1);
		cmp_v(16'(fs_rises - n), 16'h0000);
		wr_chk({7'h4e, 8'h11});
		wr_chk({7'h4f, 8'h22});
		cmp_v({9'h000, column}, 16'h0000);
		$display("test fast_host done");
		// Slow host: start after a pulse falls, end before the second rise
		@(negedge fs);
		@(posedge clk_i);
		n = fs_rises;
		i2c_seq(64'h7a008144_00000000, 4, 1'b1);
		cmp_b(fs_rises - n < 2, 1'b1);
		cmp_v({8'h00, cfg.contrast}, 16'h0044);
		$display("test slow_host done");
		tally_and_finish();
	end

	// Whole run stays under about 12k cycles; cut off at 30k
	initial begin
		#3000000;
		err_total++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		tally_and_finish();
	end
endmodule : testbench
